// >>> hdl/csbe_params.svh
// Offsets, field positions, reset values and timing for the charge status encoder
`ifndef CSBE_PARAMS_SVH
`define CSBE_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CSBE_CLK_HZ 125000000
`define CSBE_CARRIER_HZ 35000
`define CSBE_CARRIER_CYC (`CSBE_CLK_HZ / `CSBE_CARRIER_HZ)
`define CSBE_NTC_BLINK_HZ 1
`define CSBE_BAD_BLINK_HZ 4
`define CSBE_NTC_HALF_PER (`CSBE_CARRIER_HZ / (2 * `CSBE_NTC_BLINK_HZ))
`define CSBE_BAD_HALF_PER (`CSBE_CARRIER_HZ / (2 * `CSBE_BAD_BLINK_HZ))
`define CSBE_NTC_DUTY_LO 6
`define CSBE_NTC_DUTY_HI 94
`define CSBE_BAD_DUTY_LO 12
`define CSBE_BAD_DUTY_HI 88
`define CSBE_BADBAT_S 1800
`define CSBE_SAFETY_S 14400
`define CSBE_BADBAT_CYC (64'(`CSBE_CLK_HZ) * 64'(`CSBE_BADBAT_S))
`define CSBE_SAFETY_CYC (64'(`CSBE_CLK_HZ) * 64'(`CSBE_SAFETY_S))

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define CSBE_REG_CTRL 4'h0
`define CSBE_REG_STATUS 4'h4
`define CSBE_REG_INT_STAT 4'h8
`define CSBE_REG_INT_MASK 4'hC
`define CSBE_CTRL_CHG_EN 0
`define CSBE_CTRL_OTG_EN 1
`define CSBE_CTRL_RESET 8'h01
`define CSBE_INT_DONE 0
`define CSBE_INT_NTC 1
`define CSBE_INT_BADBAT 2
`define CSBE_INT_SHORT 3
`define CSBE_INT_EXPIRE 4
`define CSBE_INT_MASK_RESET 8'h00

`endif

// >>> hdl/csbe_pkg.sv
// Types shared by the charge status encoder modules
package csbe_pkg;
    typedef enum logic [1:0] {CSBE_SHOW_RELEASE, CSBE_SHOW_LOW, CSBE_SHOW_NTC, CSBE_SHOW_BAD}
        csbe_show_e;
    typedef enum logic [2:0] {CSBE_ST_OFF, CSBE_ST_TRICKLE, CSBE_ST_BULK, CSBE_ST_FLOAT,
        CSBE_ST_DONE, CSBE_ST_BADBAT} csbe_chg_e;
endpackage

// >>> hdl/csbe_pat_if.sv
// Pattern request and pin state between charger control and pattern generator
`timescale 1ns/1ns
interface csbe_pat_if;
    import csbe_pkg::*;
    csbe_show_e show;
    logic pin_low;
    logic boundary;
    modport gen (input show, output pin_low, output boundary);
    modport ctl (output show, input pin_low, input boundary);
endinterface

// >>> hdl/csbe_pattern_gen.sv
// Carrier, blink modulation and duty pattern generator for the status pin
`timescale 1ns/1ns
`include "csbe_params.svh"
module csbe_pattern_gen
    import csbe_pkg::*;
#(
    parameter int NTC_HALF_PER = `CSBE_NTC_HALF_PER,
    parameter int BAD_HALF_PER = `CSBE_BAD_HALF_PER
)(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    csbe_pat_if.gen pat
);
    localparam int PER = `CSBE_CARRIER_CYC;
    localparam int BW = 16;

    if (PER < 100 || PER > 4095 || NTC_HALF_PER < 1 || BAD_HALF_PER < 1
        || NTC_HALF_PER > 65535 || BAD_HALF_PER > 65535)
    begin : g_chk
        $error("csbe_pattern_gen: unsupported period settings");
    end

    function automatic logic [11:0] duty_cyc(input int pct);
        return 12'(PER * pct / 100);
    endfunction

    logic [11:0] cnt_q, cnt_d;
    logic [BW-1:0] blink_q, blink_d;
    logic [BW-1:0] half;
    csbe_show_e show_q, show_d;
    logic phase_q, phase_d;
    logic pin_q, pin_d;
    logic wrap;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        wrap = (cnt_q == 12'(PER - 1));
        cnt_d = wrap ? 12'h000 : cnt_q + 12'h001;
        show_d = show_q;
        phase_d = phase_q;
        blink_d = blink_q;
        half = (show_q == CSBE_SHOW_NTC) ? BW'(NTC_HALF_PER) : BW'(BAD_HALF_PER);
        if (wrap)
        begin
            // New pattern only at a period edge, so no runt pulse
            if (pat.show != show_q)
            begin
                show_d = pat.show;
                phase_d = 1'b0;
                blink_d = '0;
            end
            else if (blink_q == half - BW'(1))
            begin
                blink_d = '0;
                phase_d = ~phase_q;
            end
            else
            begin
                blink_d = blink_q + BW'(1);
            end
        end
        case (show_d)
            CSBE_SHOW_RELEASE: pin_d = 1'b0;
            CSBE_SHOW_LOW: pin_d = 1'b1;
            CSBE_SHOW_NTC: pin_d = cnt_d < (phase_d ? duty_cyc(`CSBE_NTC_DUTY_HI)
                : duty_cyc(`CSBE_NTC_DUTY_LO));
            CSBE_SHOW_BAD: pin_d = cnt_d < (phase_d ? duty_cyc(`CSBE_BAD_DUTY_HI)
                : duty_cyc(`CSBE_BAD_DUTY_LO));
            default: pin_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_q <= 12'h000;
            blink_q <= '0;
            show_q <= CSBE_SHOW_RELEASE;
            phase_q <= 1'b0;
            pin_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            blink_q <= blink_d;
            show_q <= show_d;
            phase_q <= phase_d;
            pin_q <= pin_d;
        end
    end

    assign pat.pin_low = pin_q;
    assign pat.boundary = wrap;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_release_hiz: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        show_q == CSBE_SHOW_RELEASE |-> !pin_q)
        else $error("pin driven while released");
    a_charging_low: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        show_q == CSBE_SHOW_LOW |-> pin_q)
        else $error("pin not low while charging");
    a_switch_boundary: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        show_q != $past(show_q) |-> cnt_q == 12'h000)
        else $error("pattern changed inside a period");
    a_carrier_start: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (show_q == CSBE_SHOW_NTC || show_q == CSBE_SHOW_BAD) && cnt_q == 12'h000 |-> pin_q)
        else $error("fault period does not start low");
    a_duty_ntc_lo: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        show_q == CSBE_SHOW_NTC && !phase_q && cnt_q == duty_cyc(`CSBE_NTC_DUTY_LO)
        |-> !pin_q ##1 !pin_q)
        else $error("low duty too long");
    a_blink_phase: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        phase_q != $past(phase_q) |-> cnt_q == 12'h000)
        else $error("duty changed inside a period");
endmodule

// >>> hdl/csbe_top.sv
// Charger sequencing, thermistor pause, timers and status pin encoding
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "csbe_params.svh"
// Functional notes
// - Low charging, released idle, 35kHz on faults
// - Pin low from charge start through cycle
// - Release at float and one-tenth current
// - Fault duty alternates, each half blink
// - Temperature fault 6%/94% at 1Hz
// - Bad battery 12%/88% at 4Hz
// - Bad battery after half hour trickle
// - Ignore one-tenth threshold in current limit
// - Bus short in on-the-go shows bad-battery
// - Pause charging while thermistor hot or cold
// - Float-mode safety timer holds during temperature fault
// - Grounded thermistor disables temperature features
// - Four-hour safety timer from float voltage
module csbe_top
    import csbe_pkg::*;
#(
    parameter int NTC_HALF_PER = `CSBE_NTC_HALF_PER,
    parameter int BAD_HALF_PER = `CSBE_BAD_HALF_PER,
    parameter longint BADBAT_CYC = `CSBE_BADBAT_CYC,
    parameter longint SAFETY_CYC = `CSBE_SAFETY_CYC
)(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic bat_below_trickle_i,
    input wire logic bat_at_float_i,
    input wire logic chg_below_tenth_i,
    input wire logic input_current_limit_i,
    input wire logic bat_below_recharge_i,
    input wire logic thermistor_hot_i,
    input wire logic thermistor_cold_i,
    input wire logic thermistor_sense_grounded_i,
    input wire logic otg_short_i,
    output logic charge_status_output_o,
    output logic charge_status_output_oe_o,
    output logic charge_deliver_o,
    output logic trickle_current_o,
    output logic irq_o
);
    localparam int TW = 42;

    if (BADBAT_CYC < 2 || SAFETY_CYC < 2 || BADBAT_CYC >= (64'd1 << TW)
        || SAFETY_CYC >= (64'd1 << TW))
    begin : g_chk
        $error("csbe_top: timer length out of range");
    end

    function automatic logic active_state(input csbe_chg_e s);
        return s == CSBE_ST_TRICKLE || s == CSBE_ST_BULK || s == CSBE_ST_FLOAT;
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [8:0] pins_raw;
    logic [8:0] sync1_q, sync2_q;
    assign pins_raw = {otg_short_i, thermistor_sense_grounded_i, thermistor_cold_i,
        thermistor_hot_i, bat_below_recharge_i, input_current_limit_i,
        chg_below_tenth_i, bat_at_float_i, bat_below_trickle_i};

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
        end
        else
        begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    logic below_trkl, at_float, below_tenth, in_ilim, below_rechg;
    logic ntc_hot, ntc_cold, ntc_gnd, otg_short, temp_bad;
    assign {otg_short, ntc_gnd, ntc_cold, ntc_hot, below_rechg, in_ilim,
        below_tenth, at_float, below_trkl} = sync2_q;
    assign temp_bad = (ntc_hot | ntc_cold) & ~ntc_gnd;

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0] ctrl_q, ctrl_d, mask_q, mask_d, istat_q, istat_d, rdata_q, rdata_d;
    logic [7:0] status_v, events;
    logic chg_en, otg_en;
    assign chg_en = ctrl_q[`CSBE_CTRL_CHG_EN];
    assign otg_en = ctrl_q[`CSBE_CTRL_OTG_EN];

    // ------------------------------------------------------------------------
    // Charger sequence and timers
    // ------------------------------------------------------------------------
    csbe_chg_e st_q, st_d;
    logic [TW-1:0] bad_tmr_q, bad_tmr_d, safe_tmr_q, safe_tmr_d;
    logic rel_q, rel_d, tbad_q, short_q;
    logic expire;

    always_comb
    begin
        st_d = st_q;
        bad_tmr_d = bad_tmr_q;
        safe_tmr_d = safe_tmr_q;
        rel_d = rel_q;
        expire = 1'b0;
        case (st_q)
            CSBE_ST_OFF:
            begin
                bad_tmr_d = '0;
                safe_tmr_d = '0;
                rel_d = 1'b0;
                if (chg_en)
                    st_d = below_trkl ? CSBE_ST_TRICKLE : CSBE_ST_BULK;
            end
            CSBE_ST_TRICKLE:
            begin
                if (!below_trkl)
                begin
                    bad_tmr_d = '0;
                    st_d = CSBE_ST_BULK;
                end
                else if (bad_tmr_q == TW'(BADBAT_CYC - 1))
                    st_d = CSBE_ST_BADBAT;
                else
                    bad_tmr_d = bad_tmr_q + TW'(1);
            end
            CSBE_ST_BULK:
            begin
                if (at_float)
                begin
                    safe_tmr_d = '0;
                    st_d = CSBE_ST_FLOAT;
                end
            end
            CSBE_ST_FLOAT:
            begin
                // Current limit can fake a low charge current
                if (below_tenth && !in_ilim)
                    rel_d = 1'b1;
                if (temp_bad)
                    safe_tmr_d = safe_tmr_q;
                else if (safe_tmr_q == TW'(SAFETY_CYC - 1))
                begin
                    expire = 1'b1;
                    rel_d = 1'b1;
                    st_d = CSBE_ST_DONE;
                end
                else
                    safe_tmr_d = safe_tmr_q + TW'(1);
            end
            CSBE_ST_DONE:
            begin
                if (below_rechg)
                begin
                    rel_d = 1'b0;
                    safe_tmr_d = '0;
                    st_d = CSBE_ST_BULK;
                end
            end
            CSBE_ST_BADBAT: st_d = CSBE_ST_BADBAT;
            default: st_d = CSBE_ST_OFF;
        endcase
        if (!chg_en)
            st_d = CSBE_ST_OFF;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_q <= CSBE_ST_OFF;
            bad_tmr_q <= '0;
            safe_tmr_q <= '0;
            rel_q <= 1'b0;
            tbad_q <= 1'b0;
            short_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            bad_tmr_q <= bad_tmr_d;
            safe_tmr_q <= safe_tmr_d;
            rel_q <= rel_d;
            tbad_q <= temp_bad & chg_en;
            short_q <= otg_short & otg_en;
        end
    end

    assign charge_deliver_o = active_state(st_q) && !temp_bad;
    assign trickle_current_o = (st_q == CSBE_ST_TRICKLE);

    // ------------------------------------------------------------------------
    // Status pattern selection
    // ------------------------------------------------------------------------
    csbe_pat_if pat ();
    csbe_show_e show;

    always_comb
    begin
        if (st_q == CSBE_ST_BADBAT || (otg_en && otg_short))
            show = CSBE_SHOW_BAD;
        else if (chg_en && temp_bad)
            show = CSBE_SHOW_NTC;
        else if (active_state(st_q) && !rel_q)
            show = CSBE_SHOW_LOW;
        else
            show = CSBE_SHOW_RELEASE;
    end
    assign pat.show = show;

    csbe_pattern_gen #(
        .NTC_HALF_PER(NTC_HALF_PER),
        .BAD_HALF_PER(BAD_HALF_PER)
    ) u_gen (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .pat(pat)
    );

    // Open drain: only ever pulls low
    assign charge_status_output_o = 1'b0;
    assign charge_status_output_oe_o = pat.pin_low;

    // ------------------------------------------------------------------------
    // Register bank and interrupts
    // ------------------------------------------------------------------------
    assign events = {3'b000,
        expire,
        otg_en & otg_short & ~short_q,
        (st_d == CSBE_ST_BADBAT) & (st_q != CSBE_ST_BADBAT),
        chg_en & temp_bad & ~tbad_q,
        rel_d & ~rel_q};
    assign status_v = {pat.pin_low, otg_short & otg_en, temp_bad, st_q == CSBE_ST_BADBAT,
        rel_q, st_q};

    always_comb
    begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        istat_d = istat_q;
        rdata_d = 8'h00;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `CSBE_REG_CTRL: ctrl_d = reg_wdata_i & 8'h03;
                `CSBE_REG_INT_MASK: mask_d = reg_wdata_i & 8'h1F;
                `CSBE_REG_INT_STAT: istat_d = istat_q & ~reg_wdata_i;
                default: ctrl_d = ctrl_q;
            endcase
        end
        // Set wins over a simultaneous clear
        istat_d = istat_d | events;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `CSBE_REG_CTRL: rdata_d = ctrl_q;
                `CSBE_REG_STATUS: rdata_d = status_v;
                `CSBE_REG_INT_STAT: rdata_d = istat_q;
                `CSBE_REG_INT_MASK: rdata_d = mask_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctrl_q <= `CSBE_CTRL_RESET;
            mask_q <= `CSBE_INT_MASK_RESET;
            istat_q <= 8'h00;
            rdata_q <= 8'h00;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            istat_q <= istat_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign irq_o = |(istat_q & mask_q);

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_badbat_pattern: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        st_q == CSBE_ST_BADBAT |-> show == CSBE_SHOW_BAD)
        else $error("bad battery not shown");
    a_pause_charge: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        temp_bad |-> !charge_deliver_o)
        else $error("charging during temperature fault");
    a_ntc_disable: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        ntc_gnd |-> show != CSBE_SHOW_NTC && !temp_bad)
        else $error("thermistor active while grounded");
    a_safety_hold: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        st_q == CSBE_ST_FLOAT && temp_bad && chg_en |=> safe_tmr_q == $past(safe_tmr_q))
        else $error("safety timer ran during fault");
    a_otg_short: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        otg_en && otg_short |-> show == CSBE_SHOW_BAD)
        else $error("bus short not shown");
    a_ilim_hold: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        st_q == CSBE_ST_FLOAT && in_ilim && !rel_q && safe_tmr_q != TW'(SAFETY_CYC - 1)
        |=> !rel_q)
        else $error("released in current limit");
    a_safety_expire: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        st_q == CSBE_ST_DONE |-> !charge_deliver_o && $past(st_q) inside
        {CSBE_ST_FLOAT, CSBE_ST_DONE})
        else $error("charge delivered after expiry");
    a_rise_boundary: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        pat.pin_low && !$past(pat.pin_low) |-> $past(pat.boundary))
        else $error("pin pulled low inside a period");
endmodule

// >>> tb/csbe_pin_host.sv
// Host model that times the pulled-low share of each status pin period
`timescale 1ns/1ns
`include "csbe_params.svh"
module csbe_pin_host (
    input wire logic clk_sys_i,
    input wire logic pin_i,
    output logic rep_o,
    output logic [15:0] low_o,
    output logic [15:0] len_o
);
    logic prev_q = 1'h1;
    logic armed_q = 1'h0;
    int low_q = 0;
    int len_q = 0;
    int run_q = 0;

    always @(posedge clk_sys_i)
    begin
        rep_o <= 1'h0;
        prev_q <= pin_i;
        run_q <= (pin_i == prev_q) ? run_q + 1 : 0;
        // A steady pin is no pulse train; next edge only restarts timing
        if (run_q >= `CSBE_CARRIER_CYC)
            armed_q <= 1'h0;
        if (prev_q && !pin_i)
        begin
            // Exact half reading is a blink transition, so it is dropped
            rep_o <= armed_q && (2 * low_q != len_q);
            low_o <= 16'(low_q);
            len_o <= 16'(len_q);
            armed_q <= 1'h1;
            low_q <= 1;
            len_q <= 1;
        end
        else
        begin
            low_q <= low_q + int'(!pin_i);
            len_q <= len_q + 1;
        end
    end
endmodule

// >>> tb/test_charge_status_blink_encoder.sv
// Self-checking bench for the charge status blink encoder
`timescale 1ns/1ns
`include "csbe_params.svh"
module test_charge_status_blink_encoder;
    localparam int P = `CSBE_CARRIER_CYC;
    typedef struct {bit pin; logic [15:0] v; logic [7:0] m;} csbe_note_s;
    csbe_note_s notes[$];
    int miscompares = 0;
    int checks = 0;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wd = 8'h00;
    logic [7:0] lf = 8'h61;
    logic wr = 1'h0, rd = 1'h0, rd_q = 1'h0;
    logic trk = 1'h0, flt = 1'h0, ten = 1'h0, lim = 1'h0, rch = 1'h0;
    logic hot = 1'h0, cold = 1'h0, gnd = 1'h0, sht = 1'h0;
    logic [7:0] rdata;
    logic pin_d, oe, dlv, tro, irq, rep;
    logic [15:0] lo, ln;

    always #4 clk = ~clk;

    csbe_top #(.NTC_HALF_PER(2), .BAD_HALF_PER(1), .BADBAT_CYC(4000), .SAFETY_CYC(18000))
    dut_u (
        .clk_sys_i(clk),
        .arst_n_i(rst_n),
        .reg_addr_i(addr),
        .reg_wdata_i(wd),
        .reg_wr_i(wr),
        .reg_rd_i(rd),
        .reg_rdata_o(rdata),
        .bat_below_trickle_i(trk),
        .bat_at_float_i(flt),
        .chg_below_tenth_i(ten),
        .input_current_limit_i(lim),
        .bat_below_recharge_i(rch),
        .thermistor_hot_i(hot),
        .thermistor_cold_i(cold),
        .thermistor_sense_grounded_i(gnd),
        .otg_short_i(sht),
        .charge_status_output_o(pin_d),
        .charge_status_output_oe_o(oe),
        .charge_deliver_o(dlv),
        .trickle_current_o(tro),
        .irq_o(irq)
    );

    csbe_pin_host host_u (
        .clk_sys_i(clk),
        .pin_i(oe ? pin_d : 1'h1),
        .rep_o(rep),
        .low_o(lo),
        .len_o(ln)
    );

    // --------------------
    // Tasks
    // --------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic report_and_stop();
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input bit ok, input string msg);
        checks++;
        if (!ok)
        begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        notes.push_back('{1'h0, {8'h00, e & m}, m});
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
    endtask

    task automatic expect_low(input int d);
        notes.push_back('{1'h1, 16'(d * P / 100), 8'hFF});
    endtask

    task automatic drain(input int n);
        int t = 0;
        while (notes.size() != 0 && t < n * P)
        begin
            @(posedge clk);
            t++;
        end
        check(notes.size() == 0, "pattern periods missing");
        notes.delete();
    endtask

    task automatic hold(input logic e, input int n);
        bit ok = 1'h1;
        repeat (n)
        begin
            @(posedge clk);
            ok &= (oe === e);
        end
        check(ok, "status pin level moved");
    endtask

    // Oldest note against each read answer or measured pin period
    always @(posedge clk)
    begin
        rd_q <= rd;
        if (notes.size() != 0 && (rd_q ? !notes[0].pin : rep === 1'h1 && notes[0].pin))
        begin
            if (rd_q)
                check((rdata & notes[0].m) === notes[0].v[7:0], "register read");
            else
                check(lo === notes[0].v && ln === 16'(P), "pulse period");
            void'(notes.pop_front());
        end
    end

    // --------------------
    // Sequence
    // --------------------
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        rd_reg(4'h0, `CSBE_CTRL_RESET, 8'hFF);
        rd_reg(4'hC, `CSBE_INT_MASK_RESET, 8'hFF);
        rd_reg(4'h2, 8'h00, 8'hFF);
        repeat (3)
        begin
            lf = lfsr(lf);
            wr_reg(4'hC, lf);
            rd_reg(4'hC, lf, 8'h1F);
        end
        wr_reg(4'hC, 8'h00);
        wr_reg(4'h4, 8'hFF);
        waitp(1);
        hold(1'h1, P);
        rd_reg(4'h4, 8'h82, 8'hFF);
        hot <= 1'h1;
        expect_low(`CSBE_NTC_DUTY_LO);
        expect_low(`CSBE_NTC_DUTY_HI);
        drain(5);
        check(dlv === 1'h0, "charging not paused");
        rd_reg(4'h8, 8'h02, 8'h02);
        hot <= 1'h0;
        waitp(1);
        check(dlv === 1'h1, "charging not resumed");
        hold(1'h1, P);
        gnd <= 1'h1;
        cold <= 1'h1;
        hold(1'h1, 2 * P);
        check(dlv === 1'h1, "grounded sense still pauses");
        gnd <= 1'h0;
        cold <= 1'h0;
        wr_reg(4'h0, 8'h03);
        sht <= 1'h1;
        hot <= 1'h1;
        expect_low(`CSBE_BAD_DUTY_HI);
        expect_low(`CSBE_BAD_DUTY_LO);
        drain(5);
        rd_reg(4'h4, 8'h40, 8'h40);
        wr_reg(4'h0, 8'h01);
        sht <= 1'h0;
        hot <= 1'h0;
        waitp(1);
        flt <= 1'h1;
        ten <= 1'h1;
        lim <= 1'h1;
        hold(1'h1, 2 * P);
        lim <= 1'h0;
        waitp(2);
        hold(1'h0, P);
        rd_reg(4'h4, 8'h08, 8'h88);
        rd_reg(4'h8, 8'h01, 8'h01);
        check(irq === 1'h0, "masked interrupt raised");
        wr_reg(4'hC, 8'h01);
        repeat (2) @(posedge clk);
        check(irq === 1'h1, "interrupt not raised");
        wr_reg(4'h8, 8'h01);
        repeat (2) @(posedge clk);
        check(irq === 1'h0, "interrupt not cleared");
        // Fault spans the unheld expiry point; float timer must wait
        hot <= 1'h1;
        repeat (300) @(posedge clk);
        rd_reg(4'h4, 8'h23, 8'h27);
        hot <= 1'h0;
        waitp(1);
        check(dlv === 1'h0, "charge after timer expiry");
        rd_reg(4'h8, 8'h10, 8'h10);
        flt <= 1'h0;
        ten <= 1'h0;
        trk <= 1'h1;
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h0, 8'h01);
        repeat (4) @(posedge clk);
        check(tro === 1'h1, "trickle not entered");
        expect_low(`CSBE_BAD_DUTY_HI);
        expect_low(`CSBE_BAD_DUTY_LO);
        drain(7);
        rd_reg(4'h4, 8'h15, 8'h17);
        rd_reg(4'h8, 8'h04, 8'h04);
        report_and_stop();
    end

    task automatic waitp(input int n);
        repeat (n * P) @(posedge clk);
    endtask

    // Sequence needs about 93k cycles; margin for late pattern adoption
    initial
    begin
        repeat (105000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule
